// ==== design/arl_alarm_router.v ====
// Alarm routing logic: sixteen alarm sources routed to two relays, panel
// indicators, redundancy alarm lines and a redundancy switch request.
// Assumes alarm inputs come from other clock domains or pins and that the
// route word and condition are static configuration on core_clk.
//
// Behaviour
// - Each source ignored or routed to A/B/both
// - Reset routes modulator to A, demodulator to B
// - Summary indicator is relay A OR relay B
// - Eight registered outputs from sampled alarm inputs
// - Switch request from any alarm or A/B combination
// - Unit and modulator alarm inputs accepted
// - Demod, interface and multiplexer inputs; sixteen sources
// - Separate open-collector mod and demod redundancy alarms
`timescale 1ns/1ps
`include "arl_consts.vh"

module arl_alarm_router #(
   parameter NUM_SRC = `ARL_NUM_SRC,
   parameter ROUTE_W = `ARL_ROUTE_W
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Unit alarms
   input wire ref_missing,
   input wire unit_test_active,
   input wire unit_hw_fault,
   // Modulator alarms
   input wire tx_carrier_off,
   input wire mod_rate_lock_loss,
   input wire uplink_power_control_alarm,
   input wire mod_test_active,
   input wire mod_hw_fault,
   // Demodulator alarms
   input wire dem_lock_loss,
   input wire dem_level_low,
   input wire dem_quality_low,
   input wire dem_test_active,
   input wire dem_hw_fault,
   // Interface and multiplexer alarms
   input wire if_test_active,
   input wire if_bert_sync_loss,
   input wire business_service_multiplexer_alarm,
   input wire business_service_multiplexer_fitted,
   // Configuration
   input wire route_load,
   input wire [NUM_SRC*ROUTE_W-1:0] route_cfg,
   input wire [2:0] switch_cond,
   // Outputs
   output reg relay_a_q,
   output reg relay_b_q,
   output reg mod_led_q,
   output reg dem_led_q,
   output reg summary_led_q,
   output reg mod_red_alarm_oe_q,
   output reg dem_red_alarm_oe_q,
   output reg switch_req_q,
   output reg [NUM_SRC*ROUTE_W-1:0] route_q
);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   wire [NUM_SRC-1:0] raw_src;
   reg [NUM_SRC-1:0] meta_q;
   reg [NUM_SRC-1:0] src_q;
   reg fitted_meta_q;
   reg fitted_q;

   // Placed by name so the route word and group masks line up with the pins
   assign raw_src[`ARL_SRC_REF_MISSING] = ref_missing;
   assign raw_src[`ARL_SRC_UNIT_TEST] = unit_test_active;
   assign raw_src[`ARL_SRC_UNIT_HW] = unit_hw_fault;
   assign raw_src[`ARL_SRC_TX_OFF] = tx_carrier_off;
   assign raw_src[`ARL_SRC_MOD_RATE_LOCK] = mod_rate_lock_loss;
   assign raw_src[`ARL_SRC_MOD_UPC] = uplink_power_control_alarm;
   assign raw_src[`ARL_SRC_MOD_TEST] = mod_test_active;
   assign raw_src[`ARL_SRC_MOD_HW] = mod_hw_fault;
   assign raw_src[`ARL_SRC_DEM_LOCK] = dem_lock_loss;
   assign raw_src[`ARL_SRC_DEM_LEVEL] = dem_level_low;
   assign raw_src[`ARL_SRC_DEM_QUALITY] = dem_quality_low;
   assign raw_src[`ARL_SRC_DEM_TEST] = dem_test_active;
   assign raw_src[`ARL_SRC_DEM_HW] = dem_hw_fault;
   assign raw_src[`ARL_SRC_IF_TEST] = if_test_active;
   assign raw_src[`ARL_SRC_IF_BERT] = if_bert_sync_loss;
   assign raw_src[`ARL_SRC_MUX_BACK] = business_service_multiplexer_alarm;

   // Alarm pins are asynchronous to core_clk; two stages keep metastable
   // values out of the routing, at the cost of two cycles of latency.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {NUM_SRC{1'b0}};
         src_q <= {NUM_SRC{1'b0}};
      end else begin
         meta_q <= raw_src;
         src_q <= meta_q;
      end
   end

   // The option strap is a pin too and gets its own pair of stages
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fitted_meta_q <= 1'b0;
         fitted_q <= 1'b0;
      end else begin
         fitted_meta_q <= business_service_multiplexer_fitted;
         fitted_q <= fitted_meta_q;
      end
   end

   // -----------------------------------------------------------------
   // Route table
   // -----------------------------------------------------------------
   // Held here so a reset restores the default routing even if software
   // never reloads it.
   // A load takes effect on the next edge; the outputs follow one cycle later.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         route_q <= `ARL_ROUTE_RESET;
      end else if (route_load) begin
         route_q <= route_cfg;
      end
   end

   // -----------------------------------------------------------------
   // Combining
   // -----------------------------------------------------------------
   // Returns the sources whose route code has the given bit set
   function [NUM_SRC-1:0] arl_route_sel;
      input [NUM_SRC*ROUTE_W-1:0] routes;
      input integer bitpos;
      integer i;
      begin
         arl_route_sel = {NUM_SRC{1'b0}};
         for (i = 0; i < NUM_SRC; i = i + 1) begin
            arl_route_sel[i] = routes[i*ROUTE_W+bitpos];
         end
      end
   endfunction

   // True when any source selected by the mask is active
   function arl_group_any;
      input [NUM_SRC-1:0] srcs;
      input [NUM_SRC-1:0] mask;
      begin
         arl_group_any = |(srcs & mask);
      end
   endfunction

   // Switch request for one condition code; unknown codes fall back to any
   // source, so a bad setting still lets a failing unit hand over.
   function arl_switch_sel;
      input [2:0] cond;
      input any_src;
      input rel_a;
      input rel_b;
      begin
         case (cond)
            `ARL_SW_ANY: arl_switch_sel = any_src;
            `ARL_SW_A: arl_switch_sel = rel_a;
            `ARL_SW_B: arl_switch_sel = rel_b;
            `ARL_SW_A_OR_B: arl_switch_sel = rel_a | rel_b;
            `ARL_SW_A_AND_B: arl_switch_sel = rel_a & rel_b;
            default: arl_switch_sel = any_src;
         endcase
      end
   endfunction

   reg [NUM_SRC-1:0] active;
   reg relay_a_d;
   reg relay_b_d;
   reg mod_any;
   reg dem_any;
   reg switch_req_d;
   reg summary_d;

   always @* begin
      active = src_q;
      // The backward alarm is meaningless without the option
      active[`ARL_SRC_MUX_BACK] = src_q[`ARL_SRC_MUX_BACK] & fitted_q;
      relay_a_d = |(active & arl_route_sel(route_q, `ARL_ROUTE_BIT_A));
      relay_b_d = |(active & arl_route_sel(route_q, `ARL_ROUTE_BIT_B));
      summary_d = relay_a_d | relay_b_d;
      mod_any = arl_group_any(active, `ARL_MOD_MASK);
      dem_any = arl_group_any(active, `ARL_DEM_MASK);
      switch_req_d = arl_switch_sel(switch_cond, |active, relay_a_d, relay_b_d);
   end

   // -----------------------------------------------------------------
   // Relay, summary indicator and switch-request registers
   // -----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         relay_a_q <= 1'b0;
         relay_b_q <= 1'b0;
         summary_led_q <= 1'b0;
         switch_req_q <= 1'b0;
      end else begin
         relay_a_q <= relay_a_d;
         relay_b_q <= relay_b_d;
         summary_led_q <= summary_d;
         switch_req_q <= switch_req_d;
      end
   end

   // -----------------------------------------------------------------
   // Panel and redundancy indicator registers
   // -----------------------------------------------------------------
   // Indicators follow the source groups rather than the relays, so an
   // external redundancy switch can tell a transmit fault from a receive one.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_led_q <= 1'b0;
         dem_led_q <= 1'b0;
         mod_red_alarm_oe_q <= 1'b0;
         dem_red_alarm_oe_q <= 1'b0;
      end else begin
         mod_led_q <= mod_any;
         dem_led_q <= dem_any;
         // Open collector: enable high pulls the line low, alarm asserted
         mod_red_alarm_oe_q <= mod_any;
         dem_red_alarm_oe_q <= dem_any;
      end
   end

endmodule

// ==== design/arl_consts.vh ====
// Constants for the alarm routing logic: source indices, route codes and
// switch-request condition codes. Definitions only.
`ifndef ARL_CONSTS_VH
`define ARL_CONSTS_VH

// Source count with the multiplexer option fitted
`define ARL_NUM_SRC 16
`define ARL_ROUTE_W 2

// Route codes, one per source
`define ARL_ROUTE_IGNORE 2'h0
`define ARL_ROUTE_A 2'h1
`define ARL_ROUTE_B 2'h2
`define ARL_ROUTE_AB 2'h3

// Bit of a route code that feeds each relay
`define ARL_ROUTE_BIT_A 0
`define ARL_ROUTE_BIT_B 1

// Source bit positions
`define ARL_SRC_REF_MISSING 0
`define ARL_SRC_UNIT_TEST 1
`define ARL_SRC_UNIT_HW 2
`define ARL_SRC_TX_OFF 3
`define ARL_SRC_MOD_RATE_LOCK 4
`define ARL_SRC_MOD_UPC 5
`define ARL_SRC_MOD_TEST 6
`define ARL_SRC_MOD_HW 7
`define ARL_SRC_DEM_LOCK 8
`define ARL_SRC_DEM_LEVEL 9
`define ARL_SRC_DEM_QUALITY 10
`define ARL_SRC_DEM_TEST 11
`define ARL_SRC_DEM_HW 12
`define ARL_SRC_IF_TEST 13
`define ARL_SRC_IF_BERT 14
`define ARL_SRC_MUX_BACK 15

// Masks of modulator and demodulator sources
`define ARL_MOD_MASK 16'h00F8
`define ARL_DEM_MASK 16'h1F00

// Reset value of the route word: mod sources to A, demod sources to B
`define ARL_ROUTE_RESET 32'h02AA_5540

// Switch-request condition codes
`define ARL_SW_ANY 3'h0
`define ARL_SW_A 3'h1
`define ARL_SW_B 3'h2
`define ARL_SW_A_OR_B 3'h3
`define ARL_SW_A_AND_B 3'h4

`endif

// ==== testbench/arl_alarm_router_assertions.sv ====
// Checker bound to the alarm router ports.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "arl_consts.vh"
module arl_alarm_router_assertions (
   input wire core_clk, rst_n, mod_hw_fault, dem_hw_fault, route_load,
   input wire [31:0] route_cfg, route_q,
   input wire [2:0] switch_cond,
   input wire relay_a_q, relay_b_q, mod_led_q, dem_led_q, summary_led_q,
   input wire mod_red_alarm_oe_q, dem_red_alarm_oe_q, switch_req_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Inputs cross a two-stage synchroniser, so three held samples are needed
   sequence s_mod; mod_hw_fault [*3]; endsequence
   sequence s_dem; dem_hw_fault [*3]; endsequence
   property p_rst; $rose(rst_n) |-> route_q == `ARL_ROUTE_RESET && !relay_a_q && !relay_b_q; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_sum; summary_led_q == (relay_a_q | relay_b_q); endproperty
   a_sum: assert property (p_sum) else $error("bad summary");
   property p_red; mod_red_alarm_oe_q == mod_led_q && dem_red_alarm_oe_q == dem_led_q; endproperty
   a_red: assert property (p_red) else $error("bad redundancy line");
   property p_load; route_load |=> route_q == $past(route_cfg); endproperty
   a_load: assert property (p_load) else $error("route not loaded");
   // Relay A must follow a mod_hw_fault, and relay B a dem_hw_fault, that the route word sends to it
   property p_mod;
      s_mod |=> mod_led_q && mod_red_alarm_oe_q &&
         (relay_a_q || !$past(route_q[`ARL_SRC_MOD_HW*`ARL_ROUTE_W+`ARL_ROUTE_BIT_A]));
   endproperty
   a_mod: assert property (p_mod) else $error("mod alarm lost");
   property p_dem;
      s_dem |=> dem_led_q && dem_red_alarm_oe_q &&
         (relay_b_q || !$past(route_q[`ARL_SRC_DEM_HW*`ARL_ROUTE_W+`ARL_ROUTE_BIT_B]));
   endproperty
   a_dem: assert property (p_dem) else $error("demod alarm lost");
   property p_sw; $past(switch_cond) == `ARL_SW_A_AND_B |-> switch_req_q == (relay_a_q & relay_b_q); endproperty
   a_sw: assert property (p_sw) else $error("bad switch request");
   property p_ign; $past(route_q) == 32'h0000_0000 |-> !relay_a_q && !relay_b_q; endproperty
   a_ign: assert property (p_ign) else $error("ignored source drove relay");
endmodule
bind arl_alarm_router arl_alarm_router_assertions i_chk (.*);

// ==== testbench/arl_alarm_router_test.sv ====
// Table-driven bench for the alarm router and panel model.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "arl_consts.vh"
module arl_alarm_router_test;
   reg core_clk = 1'b0;
   reg rst_n = 1'b0;
   reg fit = 1'b1;
   reg load = 1'b0;
   reg [15:0] src = 16'h0000;
   reg [31:0] cfg = 32'h0000_0000;
   reg [2:0] cond = 3'h0;
   wire [7:0] o;
   wire [31:0] rq;
   wire mline;
   wire dline;
   integer err_count = 0;
   integer tests_run = 0;
   integer i;
   reg [58:0] rows [0:6];
   arl_alarm_router i_dut (.core_clk(core_clk), .rst_n(rst_n), .ref_missing(src[0]), .unit_test_active(src[1]),
      .unit_hw_fault(src[2]), .tx_carrier_off(src[3]), .mod_rate_lock_loss(src[4]),
      .uplink_power_control_alarm(src[5]), .mod_test_active(src[6]), .mod_hw_fault(src[7]), .dem_lock_loss(src[8]),
      .dem_level_low(src[9]), .dem_quality_low(src[10]), .dem_test_active(src[11]), .dem_hw_fault(src[12]),
      .if_test_active(src[13]), .if_bert_sync_loss(src[14]), .business_service_multiplexer_alarm(src[15]),
      .business_service_multiplexer_fitted(fit), .route_load(load), .route_cfg(cfg), .switch_cond(cond),
      .relay_a_q(o[7]), .relay_b_q(o[6]), .mod_led_q(o[5]), .dem_led_q(o[4]), .summary_led_q(o[3]),
      .mod_red_alarm_oe_q(o[2]), .dem_red_alarm_oe_q(o[1]), .switch_req_q(o[0]), .route_q(rq));
   arl_panel_model i_panel (.mod_oe(o[2]), .dem_oe(o[1]), .mod_line(mline), .dem_line(dline));
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Row: sources, route word, switch condition, expected outputs
   task run(input [58:0] r);
      begin
         @(negedge core_clk);
         {src, cfg, cond} = r[58:8];
         load = 1'b1;
         @(negedge core_clk);
         load = 1'b0;
         // Synchroniser plus output stage take three edges
         repeat (5) @(negedge core_clk);
         chk({24'h0, o}, {24'h0, r[7:0]});
         chk({mline, dline}, {30'h0, ~r[2:1]});
         chk(rq, r[42:11]);
      end
   endtask
   task stop_test;
      begin
         $display("errors %0d in %0d checks", err_count, tests_run);
         if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      rows[0] = {16'h0080, 32'h02AA_5540, 3'h0, 8'hAD};
      rows[1] = {16'h1000, 32'h02AA_5540, 3'h1, 8'h5A};
      rows[2] = {16'h0004, 32'h0000_0030, 3'h4, 8'hC9};
      rows[3] = {16'h0004, 32'h0000_0000, 3'h0, 8'h01};
      rows[4] = {16'h4000, 32'h2000_0000, 3'h2, 8'h49};
      rows[5] = {16'h8000, 32'h4000_0000, 3'h3, 8'h89};
      rows[6] = {16'h0020, 32'h02AA_5540, 3'h5, 8'hAD};
      repeat (3) @(negedge core_clk);
      chk({24'h0, o}, 32'h0000_0000);
      chk(rq, 32'h02AA_5540);
      rst_n = 1'b1;
      for (i = 0; i < 7; i = i + 1) begin
         run(rows[i]);
      end
      // Multiplexer alarm must not count while the option is absent
      fit = 1'b0;
      run({16'h8000, 32'h4000_0000, 3'h1, 8'h00});
      // Mid-run reset with a demodulator fault held: default routes return
      // and the outputs stay quiet until the synchroniser has refilled
      @(negedge core_clk);
      src = 16'h1000;
      rst_n = 1'b0;
      @(negedge core_clk);
      chk({24'h0, o}, 32'h0000_0000);
      chk(rq, 32'h02AA_5540);
      rst_n = 1'b1;
      repeat (2) begin
         @(negedge core_clk);
         chk({24'h0, o}, 32'h0000_0000);
      end
      @(negedge core_clk);
      chk({24'h0, o}, 32'h0000_005A);
      chk({mline, dline}, 32'h0000_0002);
      stop_test;
   end
endmodule

// ==== testbench/arl_panel_model.sv ====
// Far side: open-collector redundancy lines with pull-ups.
// Assumes the enables come straight from the router.
`timescale 1ns/1ps
module arl_panel_model (
   input wire mod_oe,
   input wire dem_oe,
   output wire mod_line,
   output wire dem_line
);
   // Pulled high unless the router sinks the line
   assign mod_line = mod_oe ? 1'b0 : 1'b1;
   assign dem_line = dem_oe ? 1'b0 : 1'b1;
endmodule
